/* logic/dse_pkg.sv */
/*
 * dse_pkg: shared constants for the data-space decoder and nonvolatile byte port.
 * Assumes one 100 MHz core clock; the write timer runs from a 1 MHz enable derived from it.
 */
package dse_pkg;
    // data-space map
    localparam logic [15:0] IO_BASE = 16'h0020;
    localparam logic [15:0] SRAM_BASE = 16'h0060;
    localparam logic [15:0] SRAM_END = 16'h045f;
    localparam int SRAM_WORDS = 1024;
    localparam int SRAM_AW = 10;
    // nonvolatile store geometry
    localparam int NV_BYTES = 512;
    localparam int NV_AW = 9;
    // io register slots of the nonvolatile port
    localparam logic [5:0] IO_NV_CTRL = 6'h1c;
    localparam logic [5:0] IO_NV_DATA = 6'h1d;
    localparam logic [5:0] IO_NV_ADDR_LO = 6'h1e;
    localparam logic [5:0] IO_NV_ADDR_HI = 6'h1f;
    // control register bit positions
    localparam int BIT_RD = 0;
    localparam int BIT_WS = 1;
    localparam int BIT_ARM = 2;
    localparam int BIT_IE = 3;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [NV_AW-1:0] NV_ADDR_RESET = 9'h000;
    localparam logic [7:0] NV_DATA_RESET = 8'h00;
    // core stall lengths and arm window, in core cycles
    localparam logic [2:0] RD_STALL = 3'h4;
    localparam logic [2:0] WR_STALL = 3'h2;
    localparam logic [2:0] ARM_WINDOW = 3'h4;
    // timing: write time is counted in oscillator periods
    localparam int CLK_PERIOD_NS = 10;
    localparam int OSC_PERIOD_NS = 1000;
    localparam int OSC_DIV = OSC_PERIOD_NS / CLK_PERIOD_NS;
    localparam int NV_WRITE_TICKS = 8448;
    // address generation modes
    typedef enum logic [2:0] {
        AG_DIRECT = 3'b000,
        AG_IND = 3'b001,
        AG_DISP = 3'b010,
        AG_PREDEC = 3'b011,
        AG_POSTINC = 3'b100
    } dse_agmode_e;
    // programming state of the store
    typedef enum logic {
        NV_IDLE = 1'b0,
        NV_PROG = 1'b1
    } dse_nv_state_e;
endpackage

/* logic/dse_tick_div.sv */
/*
 * dse_tick_div: divides the core clock into a one-cycle enable pulse.
 * Assumes DIV of two or more; the pulse stands in for the slow oscillator.
 */
`timescale 1ns/1ps
module dse_tick_div #(
    parameter int DIV = 100
) (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    output logic tick_o
);
    localparam int W = $clog2(DIV);
    logic [W-1:0] cnt_q;

    // free-running counter, pulse on wrap
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            cnt_q <= '0;
            tick_o <= 1'b0;
        end
        else
        begin
            tick_o <= (cnt_q == W'(DIV - 1));
            cnt_q <= (cnt_q == W'(DIV - 1)) ? '0 : cnt_q + 1'b1;
        end
    end
endmodule

/* logic/dse_nv_store.sv */
/*
 * dse_nv_store: 512-byte nonvolatile array with a self-timed write.
 * Assumes reads are never asked while busy; the caller filters them.
 */
`timescale 1ns/1ps
module dse_nv_store
    import dse_pkg::*;
#(
    parameter int WRITE_TICKS = 8448
) (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic tick_i,
    input wire logic rd_i,
    input wire logic wr_i,
    input wire logic [dse_pkg::NV_AW-1:0] addr_i,
    input wire logic [7:0] wdata_i,
    output logic [7:0] rdata_o,
    output logic busy_o
);
    localparam int CW = $clog2(WRITE_TICKS + 1);
    logic [7:0] mem_q [NV_BYTES];
    dse_nv_state_e state_q;
    logic [CW-1:0] cnt_q;
    logic [NV_AW-1:0] waddr_q;
    logic [7:0] wdata_q;
    logic done;

    assign done = (state_q == NV_PROG) && tick_i && (cnt_q == CW'(WRITE_TICKS - 1));
    assign busy_o = (state_q == NV_PROG);

    // programming sequencer; address and byte are captured at start
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            state_q <= NV_IDLE;
            cnt_q <= '0;
            waddr_q <= NV_ADDR_RESET;
            wdata_q <= NV_DATA_RESET;
        end
        else
        begin
            case (state_q)
                NV_IDLE:
                begin
                    if (wr_i)
                    begin
                        state_q <= NV_PROG;
                        cnt_q <= '0;
                        waddr_q <= addr_i;
                        wdata_q <= wdata_i;
                    end
                end
                NV_PROG:
                begin
                    if (done)
                    begin
                        state_q <= NV_IDLE; // (RQ19)
                    end
                    else if (tick_i)
                    begin
                        cnt_q <= cnt_q + 1'b1;
                    end
                end
                default:
                begin
                    state_q <= NV_IDLE;
                end
            endcase
        end
    end

    // array: byte lands when the write time ends
    always_ff @(posedge sys_clk_i)
    begin
        if (done)
        begin
            mem_q[waddr_q] <= wdata_q; // (RQ1)
        end
    end

    // registered read port
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            rdata_o <= NV_DATA_RESET;
        end
        else if (rd_i)
        begin
            rdata_o <= mem_q[addr_i]; // (RQ6)
        end
    end

    AST_PROG_NO_EARLY_END: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (busy_o && !tick_i) |=> busy_o) // (RQ19)
        else $error("programming ended without an oscillator tick");
endmodule

/* logic/dse_top.sv */
/*
 * dse_top: data-space decoder, pointer address generator, internal SRAM and the
 * io-mapped nonvolatile byte port with its arm window, write timer and core stall.
 * Assumes the core issues at most one access per cycle, same clock, and none while
 * core_advance_o is low; working registers and other io registers live in the core.
 */
// Functional notes
// (RQ1) a separate 512-byte nonvolatile store, byte access, outside data space
// (RQ2) nine-bit store address, linear bytes 0 through 511
// (RQ3) address bits 15..9 read back as zero
// (RQ4) address undefined after reset; software loads it before any access
// (RQ5) a write stores the data register byte at the current address
// (RQ6) a read loads the data register with the addressed byte
// (RQ7) a triggered read stalls the core four cycles
// (RQ8) a triggered write stalls the core two cycles
// (RQ9) self-timed write; busy status tells when next byte may go
// (RQ10) write accepted only after the arming sequence
// (RQ11) address, data and control registers sit in io space
// (RQ12) first 96 addresses: 32 working registers then 64 io registers
// (RQ13) next 1024 addresses are SRAM, 1120 locations in all
// (RQ14) each SRAM access completes in two core cycles
// (RQ15) displacement mode adds unsigned offset up to 63 to pointer
// (RQ16) pre-decrement and post-increment update the pointer used
// (RQ17) direct addressing reaches the whole data space
// (RQ18) strobe must follow arm within four cycles; arm self-clears after four
// (RQ19) strobe bit stays set while programming, cleared after 8448 ticks
// (RQ20) read strobe triggers read; while busy reads refused, address frozen
// (RQ21) ready interrupt level while enabled and strobe bit clear
// (RQ22) writes to reserved address bits ignored, they hold zero
// (RQ23) advance held low exactly the stall count, then released
`timescale 1ns/1ps
module dse_top
    import dse_pkg::*;
#(
    parameter int WRITE_TICKS = dse_pkg::NV_WRITE_TICKS
) (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic [15:0] dm_addr_i,
    input wire logic dm_rd_i,
    input wire logic dm_wr_i,
    input wire logic [7:0] dm_wdata_i,
    output logic [7:0] dm_rdata_o,
    output logic dm_ack_o,
    output logic sel_regfile_o,
    output logic sel_io_o,
    output logic sel_sram_o,
    input wire dse_pkg::dse_agmode_e ag_mode_i,
    input wire logic [15:0] ag_direct_i,
    input wire logic [15:0] ag_ptr_i,
    input wire logic [5:0] ag_disp_i,
    output logic [15:0] ag_addr_o,
    output logic [15:0] ag_ptr_next_o,
    output logic ag_ptr_wr_o,
    output logic core_advance_o,
    output logic ready_irq_o
);
    logic in_rf;
    logic in_io;
    logic in_sram;
    logic [15:0] io_off;
    logic [15:0] sram_off;
    logic [5:0] io_idx;
    logic [SRAM_AW-1:0] sram_idx;
    logic acc_rd;
    logic acc_wr;
    logic ctrl_wr;
    logic rd_trig;
    logic wr_trig;
    logic arm_set;
    logic nv_busy;
    logic nv_tick;
    logic [7:0] nv_rdata;
    logic [7:0] sram_q [SRAM_WORDS];
    logic [NV_AW-1:0] nv_addr_q;
    logic [7:0] nv_data_q;
    logic ie_q;
    logic [2:0] arm_cnt_q;
    logic arm_q;
    logic [2:0] stall_q;
    logic rd_pend_q;
    logic [7:0] rdata_d;
    logic [7:0] ctrl_view;

    // region decode of the incoming data address
    assign io_off = dm_addr_i - IO_BASE;
    assign sram_off = dm_addr_i - SRAM_BASE;
    assign io_idx = io_off[5:0];
    assign sram_idx = sram_off[SRAM_AW-1:0];
    assign in_rf = (dm_addr_i < IO_BASE); // (RQ12)
    assign in_io = (dm_addr_i >= IO_BASE) && (dm_addr_i < SRAM_BASE); // (RQ12)
    assign in_sram = (dm_addr_i >= SRAM_BASE) && (dm_addr_i <= SRAM_END); // (RQ13)
    assign sel_regfile_o = in_rf;
    assign sel_io_o = in_io;
    assign sel_sram_o = in_sram;

    // requests only count while the core advances
    assign acc_rd = dm_rd_i && core_advance_o;
    assign acc_wr = dm_wr_i && core_advance_o;

    // effective address and pointer update
    always_comb
    begin
        ag_addr_o = ag_direct_i; // (RQ17)
        ag_ptr_next_o = ag_ptr_i;
        ag_ptr_wr_o = 1'b0;
        case (ag_mode_i)
            AG_DIRECT:
            begin
                ag_addr_o = ag_direct_i; // (RQ17)
            end
            AG_IND:
            begin
                ag_addr_o = ag_ptr_i;
            end
            AG_DISP:
            begin
                ag_addr_o = ag_ptr_i + {10'h000, ag_disp_i}; // (RQ15)
            end
            AG_PREDEC:
            begin
                ag_addr_o = ag_ptr_i - 16'h0001; // (RQ16)
                ag_ptr_next_o = ag_ptr_i - 16'h0001;
                ag_ptr_wr_o = 1'b1;
            end
            AG_POSTINC:
            begin
                ag_addr_o = ag_ptr_i; // (RQ16)
                ag_ptr_next_o = ag_ptr_i + 16'h0001;
                ag_ptr_wr_o = 1'b1;
            end
            default:
            begin
                ag_addr_o = ag_direct_i;
            end
        endcase
    end

    // control strobes from io writes to the port
    assign ctrl_wr = acc_wr && in_io && (io_idx == IO_NV_CTRL); // (RQ11)
    assign arm_set = ctrl_wr && dm_wdata_i[BIT_ARM];
    assign rd_trig = ctrl_wr && dm_wdata_i[BIT_RD] && !nv_busy; // (RQ20)
    // arm must already be open; setting both at once does not program
    assign wr_trig = ctrl_wr && dm_wdata_i[BIT_WS] && arm_q && !nv_busy; // (RQ10)

    // arm window: a fresh arm write reloads the count and wins over timeout
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            arm_cnt_q <= 3'h0;
        end
        else if (arm_set)
        begin
            arm_cnt_q <= ARM_WINDOW; // (RQ18)
        end
        else if (arm_cnt_q != 3'h0)
        begin
            arm_cnt_q <= arm_cnt_q - 3'h1; // (RQ18)
        end
    end
    assign arm_q = (arm_cnt_q != 3'h0);

    // ready interrupt enable
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            ie_q <= CTRL_RESET[BIT_IE];
        end
        else if (ctrl_wr)
        begin
            ie_q <= dm_wdata_i[BIT_IE];
        end
    end

    // level request, no flag: it simply follows the strobe bit
    assign ready_irq_o = ie_q && !nv_busy; // (RQ21)

    // address pair; frozen while programming, upper bits never stored
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            nv_addr_q <= NV_ADDR_RESET; // (RQ4)
        end
        else if (acc_wr && in_io && !nv_busy)
        begin
            if (io_idx == IO_NV_ADDR_LO)
            begin
                nv_addr_q[7:0] <= dm_wdata_i; // (RQ2)
            end
            else if (io_idx == IO_NV_ADDR_HI)
            begin
                nv_addr_q[8] <= dm_wdata_i[0]; // (RQ22)
            end
        end
    end

    // data byte: read result wins over a core write in the same cycle
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            nv_data_q <= NV_DATA_RESET;
        end
        else if (rd_pend_q)
        begin
            nv_data_q <= nv_rdata; // (RQ6)
        end
        else if (acc_wr && in_io && (io_idx == IO_NV_DATA))
        begin
            nv_data_q <= dm_wdata_i; // (RQ5)
        end
    end

    // marks the cycle the store's read data is valid
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            rd_pend_q <= 1'b0;
        end
        else
        begin
            rd_pend_q <= rd_trig;
        end
    end

    // core stall counter; advance is low exactly while it runs
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            stall_q <= 3'h0;
        end
        else if (rd_trig)
        begin
            stall_q <= RD_STALL; // (RQ7)
        end
        else if (wr_trig)
        begin
            stall_q <= WR_STALL; // (RQ8)
        end
        else if (stall_q != 3'h0)
        begin
            stall_q <= stall_q - 3'h1; // (RQ23)
        end
    end
    assign core_advance_o = (stall_q == 3'h0); // (RQ23)

    // internal SRAM write port
    always_ff @(posedge sys_clk_i)
    begin
        if (acc_wr && in_sram)
        begin
            sram_q[sram_idx] <= dm_wdata_i; // (RQ13)
        end
    end

    // control view: upper bits zero, read strobe self-clears
    assign ctrl_view = {4'h0, ie_q, arm_q, nv_busy, 1'b0}; // (RQ9)

    // read mux; core-owned locations answer zero here
    always_comb
    begin
        rdata_d = 8'h00;
        if (in_sram)
        begin
            rdata_d = sram_q[sram_idx];
        end
        else if (in_io)
        begin
            case (io_idx)
                IO_NV_CTRL: rdata_d = ctrl_view;
                IO_NV_DATA: rdata_d = nv_data_q;
                IO_NV_ADDR_LO: rdata_d = nv_addr_q[7:0];
                IO_NV_ADDR_HI: rdata_d = {7'h00, nv_addr_q[8]}; // (RQ3)
                default: rdata_d = 8'h00;
            endcase
        end
    end

    // answer one cycle after the request: two core cycles per access
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            dm_ack_o <= 1'b0;
            dm_rdata_o <= 8'h00;
        end
        else
        begin
            dm_ack_o <= acc_rd || acc_wr; // (RQ14)
            if (acc_rd)
            begin
                dm_rdata_o <= rdata_d;
            end
        end
    end

    // slow enable standing in for the 1 MHz oscillator
    dse_tick_div #(
        .DIV(OSC_DIV)
    ) u_div (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .tick_o(nv_tick)
    );

    // the byte store and its write timer
    dse_nv_store #(
        .WRITE_TICKS(WRITE_TICKS)
    ) u_store (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .tick_i(nv_tick),
        .rd_i(rd_trig),
        .wr_i(wr_trig),
        .addr_i(nv_addr_q),
        .wdata_i(nv_data_q),
        .rdata_o(nv_rdata),
        .busy_o(nv_busy)
    );

    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);

    AST_RD_STALL: assert property (rd_trig |=> !core_advance_o [*4] ##1 core_advance_o) // (RQ7)
        else $error("read stall is not four cycles");
    AST_WR_STALL: assert property (wr_trig |=> !core_advance_o [*2] ##1 core_advance_o) // (RQ8)
        else $error("write stall is not two cycles");
    AST_ARM_WINDOW: assert property (arm_set |=> arm_q [*4]) // (RQ18)
        else $error("arm window shorter than four cycles");
    AST_ARM_TIMEOUT: assert property ((!arm_set) [*5] |-> !arm_q) // (RQ18)
        else $error("arm bit outlived its window");
    AST_NO_UNARMED_WRITE: assert property ((ctrl_wr && dm_wdata_i[BIT_WS] && !arm_q && !nv_busy) |=> !nv_busy) // (RQ10)
        else $error("write started without arming");
    AST_WR_BUSY: assert property (wr_trig |=> nv_busy && ctrl_view[BIT_WS]) // (RQ9)
        else $error("strobe bit not set after write start");
    AST_ADDR_FROZEN: assert property (nv_busy |=> $stable(nv_addr_q)) // (RQ20)
        else $error("address changed during programming");
    AST_RD_LOAD: assert property (rd_trig |=> ##1 (nv_data_q == $past(nv_rdata))) // (RQ6)
        else $error("read byte not loaded into data register");
    AST_IRQ_DROP: assert property ((wr_trig && ie_q) |=> !ready_irq_o) // (RQ21)
        else $error("ready request stayed up during programming");
    AST_HI_ZERO: assert property ((acc_rd && in_io && io_idx == IO_NV_ADDR_HI) |=> dm_rdata_o[7:1] == 7'h00) // (RQ3)
        else $error("reserved address bits read nonzero");
    AST_SRAM_ACK: assert property ((acc_rd && in_sram) |=> dm_ack_o) // (RQ14)
        else $error("sram access not answered in two cycles");

    COV_READ: cover property (rd_trig ##5 core_advance_o);
    COV_WRITE: cover property (arm_set ##2 wr_trig);
    COV_ARM_LAPSE: cover property (arm_q ##1 !arm_q);
    COV_SRAM_RD: cover property (acc_rd && in_sram);
endmodule

/* verif/dse_core_model.sv */
/*
 * dse_core_model: load/store side of the core, one data-space access at a time.
 * Assumes callers enter its tasks on a rising edge of the core clock.
 */
`timescale 1ns/1ps
module dse_core_model (
    input wire logic sys_clk_i,
    input wire logic core_advance_i,
    input wire logic dm_ack_i,
    input wire logic [7:0] dm_rdata_i,
    output logic [15:0] dm_addr_o,
    output logic dm_rd_o,
    output logic dm_wr_o,
    output logic [7:0] dm_wdata_o
);
    // idle bus at time zero
    initial
    begin
        dm_addr_o = 16'h0000;
        dm_rd_o = 1'b0;
        dm_wr_o = 1'b0;
        dm_wdata_o = 8'h00;
    end

    // park an address without a strobe, for decode checks
    task automatic put_addr(input logic [15:0] a);
        dm_addr_o <= a;
    endtask

    // one access; stall counts the edges that advance stays low after the ack
    task automatic access(input logic w, input logic [15:0] a, input logic [7:0] d,
                          output logic [7:0] q, output logic ack, output int stall);
        int n;
        n = 0;
        while (core_advance_i !== 1'b1 && n < 20)
        begin
            @(posedge sys_clk_i);
            n++;
        end
        dm_addr_o <= a;
        dm_wdata_o <= d;
        dm_wr_o <= w;
        dm_rd_o <= !w;
        @(posedge sys_clk_i);
        // taken here; scramble released lines so stale values cannot pass
        dm_rd_o <= 1'b0;
        dm_wr_o <= 1'b0;
        dm_addr_o <= ~a;
        dm_wdata_o <= ~d;
        @(posedge sys_clk_i);
        ack = dm_ack_i;
        q = dm_rdata_i;
        stall = (n < 20) ? 0 : 99;
        while (core_advance_i !== 1'b1 && stall < 20)
        begin
            @(posedge sys_clk_i);
            stall++;
        end
    endtask
endmodule

/* verif/dse_top_tb_top.sv */
/*
 * dse_top_tb_top: self-checking bench for the data-space decoder and nonvolatile port.
 * Assumes dse_core_model drives the data-space port; write time cut to 3 ticks.
 */
`timescale 1ns/1ps
module dse_top_tb_top;
    import dse_pkg::*;
    localparam int TICKS = 3;
    localparam logic [15:0] A_CTRL = IO_BASE + {10'h000, IO_NV_CTRL};
    localparam logic [15:0] A_DATA = IO_BASE + {10'h000, IO_NV_DATA};
    localparam logic [15:0] A_LO = IO_BASE + {10'h000, IO_NV_ADDR_LO};
    localparam logic [15:0] A_HI = IO_BASE + {10'h000, IO_NV_ADDR_HI};
    localparam logic [15:0] DEC_A [8] = '{16'h0000, 16'h001f, 16'h0020, 16'h005f,
                                         16'h0060, 16'h045f, 16'h0460, 16'hffff};
    localparam logic [2:0] DEC_S [8] = '{3'b100, 3'b100, 3'b010, 3'b010, 3'b001, 3'b001, 3'b000, 3'b000};
    localparam dse_agmode_e AGM [6] = '{AG_DIRECT, AG_IND, AG_DISP, AG_PREDEC, AG_POSTINC, AG_PREDEC};
    localparam logic [15:0] AGP [6] = '{16'h1234, 16'h1234, 16'h1234, 16'h1234, 16'h1234, 16'h0000};
    localparam logic [15:0] AGA [6] = '{16'h045f, 16'h1234, 16'h1273, 16'h1233, 16'h1234, 16'hffff};
    localparam logic [15:0] AGN [6] = '{16'h1234, 16'h1234, 16'h1234, 16'h1233, 16'h1235, 16'hffff};
    localparam logic AGW [6] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
    logic sys_clk;
    logic rst;
    logic [15:0] dm_addr;
    logic dm_rd;
    logic dm_wr;
    logic [7:0] dm_wdata;
    logic [7:0] dm_rdata;
    logic dm_ack;
    logic sel_regfile;
    logic sel_io;
    logic sel_sram;
    dse_agmode_e ag_mode;
    logic [15:0] ag_direct;
    logic [15:0] ag_ptr;
    logic [5:0] ag_disp;
    logic [15:0] ag_addr;
    logic [15:0] ag_ptr_next;
    logic ag_ptr_wr;
    logic core_advance;
    logic ready_irq;
    int failures;
    int n_checks;

    dse_top #(.WRITE_TICKS(TICKS)) u_dse_top (.sys_clk_i(sys_clk), .rst_i(rst), .dm_addr_i(dm_addr),
        .dm_rd_i(dm_rd), .dm_wr_i(dm_wr), .dm_wdata_i(dm_wdata), .dm_rdata_o(dm_rdata), .dm_ack_o(dm_ack),
        .sel_regfile_o(sel_regfile), .sel_io_o(sel_io), .sel_sram_o(sel_sram), .ag_mode_i(ag_mode),
        .ag_direct_i(ag_direct), .ag_ptr_i(ag_ptr), .ag_disp_i(ag_disp), .ag_addr_o(ag_addr),
        .ag_ptr_next_o(ag_ptr_next), .ag_ptr_wr_o(ag_ptr_wr), .core_advance_o(core_advance),
        .ready_irq_o(ready_irq));
    dse_core_model u_dse_core_model (.sys_clk_i(sys_clk), .core_advance_i(core_advance), .dm_ack_i(dm_ack),
        .dm_rdata_i(dm_rdata), .dm_addr_o(dm_addr), .dm_rd_o(dm_rd), .dm_wr_o(dm_wr), .dm_wdata_o(dm_wdata));

    // 100 MHz core clock
    always #5 sys_clk = ~sys_clk;

    task automatic end_of_test();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
        begin
            $display("NO MISMATCHES");
        end
        else
        begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // compare tasks: four-state values and cycle counts
    task automatic chk_val(input string nm, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic chk_cnt(input string nm, input int exp, input int got);
        n_checks++;
        if (got != exp)
        begin
            failures++;
            $display("CHECK FAILED %s expected %0d seen %0d", nm, exp, got);
        end
    endtask

    // bus access through the core model; a hung stall ends the run
    task automatic bus(input logic w, input logic [15:0] a, input logic [7:0] d, input int est,
                       output logic [7:0] q);
        logic ak;
        int st;
        u_dse_core_model.access(w, a, d, q, ak, st);
        chk_val("ack", 16'h0001, {15'h0000, ak});
        chk_cnt("stall", est, st);
        if (st >= 20)
        begin
            end_of_test();
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d, input int est);
        logic [7:0] q;
        bus(1'b1, a, d, est, q);
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] exp, input string nm);
        logic [7:0] q;
        bus(1'b0, a, 8'h00, 0, q);
        chk_val(nm, {8'h00, exp}, {8'h00, q});
    endtask

    // poll the busy bit; the poll count brackets the self-timed write length
    task automatic wait_idle();
        logic [7:0] q;
        int n;
        n = 0;
        q = 8'h02;
        while (q[BIT_WS] !== 1'b0 && n < 400)
        begin
            bus(1'b0, A_CTRL, 8'h00, 0, q);
            n++;
        end
        chk_cnt("busy polls in range", 1, int'(n >= (TICKS - 1) * OSC_DIV / 2 - 5 && n <= TICKS * OSC_DIV / 2 + 5));
        if (n >= 400)
        begin
            end_of_test();
        end
    endtask

    task automatic t_reset();
        chk_val("advance after reset", 16'h0001, {15'h0000, core_advance});
        chk_val("irq after reset", 16'h0000, {15'h0000, ready_irq});
        rd(A_CTRL, CTRL_RESET, "ctrl reset");
        rd(A_HI, 8'h00, "addr hi reset");
    endtask

    task automatic t_decode();
        for (int i = 0; i < 8; i++)
        begin
            u_dse_core_model.put_addr(DEC_A[i]);
            @(posedge sys_clk);
            chk_val("region select", {13'h0000, DEC_S[i]}, {13'h0000, sel_regfile, sel_io, sel_sram});
        end
    endtask

    task automatic t_sram();
        wr(16'h0060, 8'h3c, 0);
        wr(16'h045f, 8'hc5, 0);
        rd(16'h0060, 8'h3c, "sram first");
        rd(16'h045f, 8'hc5, "sram last");
        wr(16'h0460, 8'h77, 0);
        rd(16'h0460, 8'h00, "unmapped");
    endtask

    task automatic t_addr_reg();
        wr(A_HI, 8'hff, 0);
        rd(A_HI, 8'h01, "addr hi reserved");
        wr(A_LO, 8'ha5, 0);
        rd(A_LO, 8'ha5, "addr lo");
    endtask

    // armed write with ready interrupt enabled; refusals checked mid-programming
    task automatic nv_write(input logic [8:0] a, input logic [7:0] d);
        wr(A_LO, a[7:0], 0);
        wr(A_HI, {7'h00, a[8]}, 0);
        wr(A_DATA, d, 0);
        wr(A_CTRL, 8'h0c, 0);
        wr(A_CTRL, 8'h0a, 2);
        chk_val("irq while busy", 16'h0000, {15'h0000, ready_irq});
        rd(A_CTRL, 8'h0a, "ctrl busy");
        wr(A_LO, ~a[7:0], 0);
        rd(A_LO, a[7:0], "addr frozen");
        wr(A_CTRL, 8'h09, 0);
        wait_idle();
        chk_val("irq when ready", 16'h0001, {15'h0000, ready_irq});
        rd(A_DATA, d, "data kept after refused read");
    endtask
    task automatic nv_read(input logic [8:0] a, input logic [7:0] exp);
        wr(A_LO, a[7:0], 0);
        wr(A_HI, {7'h00, a[8]}, 0);
        wr(A_CTRL, 8'h01, 4);
        rd(A_DATA, exp, "store byte");
    endtask
    task automatic t_store();
        nv_write(9'h1ff, 8'h5a);
        nv_write(9'h000, 8'hc3);
        nv_read(9'h1ff, 8'h5a);
        nv_read(9'h000, 8'hc3);
    endtask

    // arm and strobe in one write, or strobe just past the window: refused; last open cycle: taken
    task automatic t_arm();
        wr(A_CTRL, 8'h06, 0);
        repeat (6) @(posedge sys_clk);
        rd(A_CTRL, 8'h00, "no program same write");
        wr(A_CTRL, 8'h04, 0);
        repeat (3) @(posedge sys_clk);
        wr(A_CTRL, 8'h02, 0);
        rd(A_CTRL, 8'h00, "no program late strobe");
        wr(A_CTRL, 8'h04, 0);
        repeat (2) @(posedge sys_clk);
        wr(A_CTRL, 8'h02, 2);
        rd(A_CTRL, 8'h02, "program in last arm cycle");
        wait_idle();
    endtask

    task automatic t_agen();
        for (int i = 0; i < 6; i++)
        begin
            ag_mode <= AGM[i];
            ag_ptr <= AGP[i];
            @(posedge sys_clk);
            chk_val("effective address", AGA[i], ag_addr);
            chk_val("pointer next", AGN[i], ag_ptr_next);
            chk_val("pointer write", {15'h0000, AGW[i]}, {15'h0000, ag_ptr_wr});
        end
    endtask

    // main sequence: reset for three cycles, then each scenario
    initial
    begin
        failures = 0;
        n_checks = 0;
        sys_clk = 1'b0;
        rst = 1'b1;
        ag_mode = AG_DIRECT;
        ag_direct = 16'h045f;
        ag_ptr = 16'h0000;
        ag_disp = 6'h3f;
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        t_reset();
        t_decode();
        t_sram();
        t_addr_reg();
        t_store();
        t_arm();
        t_agen();
        end_of_test();
    end
endmodule
